//--- include/serial_port_pkg.sv
// Shared constants and types for the asynchronous serial port
// Functional notes
// - Full duplex, one byte after start
// - Dedicated bit rate generator, many rates
// - Mode register selects asynchronous operation
// - Transmit write loads and starts sending
// - Seven-bit length sends bits zero-six
// - Transmit write-only, reads return receive
// - Completed character moves to receive buffer
// - Seven-bit receive keeps MSB zero
// - Receive read-only, writes go to transmit
// - Mode register byte or bit writable
// - Divider register written as whole byte
// - Rate is fx/(2^(n+1)*(k+16))
// - Exponent n from prescaler field, 1..7
// - Offset k from modulus field, 0..14
package serial_port_pkg;
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 8;
   localparam int ADDR_W = 2;

   // Register map
   localparam logic [ADDR_W-1:0] ADDR_DATA = 2'h0;
   localparam logic [ADDR_W-1:0] ADDR_MODE = 2'h1;
   localparam logic [ADDR_W-1:0] ADDR_DIV = 2'h2;
   localparam logic [ADDR_W-1:0] ADDR_STAT = 2'h3;

   // Mode control fields
   localparam int MODE_TX_EN = 7;
   localparam int MODE_RX_EN = 6;
   localparam int MODE_ASYNC = 5;
   localparam int MODE_LEN8 = 2;
   localparam logic [7:0] MODE_RST = 8'h00;

   // Divider fields
   localparam int DIV_N_HI = 6;
   localparam int DIV_N_LO = 4;
   localparam int DIV_K_HI = 3;
   localparam int DIV_K_LO = 0;
   localparam logic [7:0] DIV_RST = 8'h10;
   localparam logic [2:0] N_MIN = 3'h1;
   localparam logic [3:0] K_MAX = 4'he;
   localparam logic [4:0] MOD_BASE = 5'h10;

   // Status fields
   localparam int STAT_TX_BUSY = 0;
   localparam int STAT_RX_READY = 1;
   localparam int STAT_OVERRUN = 2;
   localparam int STAT_FRAME_ERR = 3;

   localparam logic [3:0] BITS_8 = 4'h8;
   localparam logic [3:0] BITS_7 = 4'h7;

   typedef enum logic [3:0] {
      TX_IDLE = 4'b0001,
      TX_START = 4'b0010,
      TX_DATA = 4'b0100,
      TX_STOP = 4'b1000
   } tx_state_t;

   typedef enum logic [3:0] {
      RX_IDLE = 4'b0001,
      RX_START = 4'b0010,
      RX_DATA = 4'b0100,
      RX_STOP = 4'b1000
   } rx_state_t;
endpackage : serial_port_pkg

//--- verilog/serial_rx_fifo.sv
// Parameterised valid/ready FIFO for received characters
`timescale 1ns/100ps
`default_nettype none
module serial_rx_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
   localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PTR_W-1:0] wr_ptr_q;
   logic [PTR_W-1:0] rd_ptr_q;
   logic [CNT_W-1:0] count_q;
   logic push;
   logic pop;

   assign in_ready = (count_q != FULL_CNT);
   assign out_valid = (count_q != '0);
   assign out_data = mem_q[rd_ptr_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + 1'b1;
         end
         if (push && !pop) begin
            count_q <= count_q + 1'b1;
         end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
         end
      end
   end
endmodule : serial_rx_fifo
`default_nettype wire

//--- verilog/async_serial_port_with_baud_gen.sv
// Asynchronous serial port with its own bit rate generator
`timescale 1ns/100ps
`default_nettype none
module async_serial_port_with_baud_gen
   import serial_port_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // CPU register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_bit_set,
   input wire logic reg_bit_clr,
   input wire logic [2:0] reg_bit_sel,
   output logic [7:0] reg_rdata,
   // Serial line
   input wire logic rxd,
   output logic txd
);
   logic [7:0] mode_q;
   logic [7:0] div_q;
   logic [7:0] rdata_q;
   logic txd_q;

   // Effective exponent; zero in the field would give no division at all
   function automatic logic [2:0] eff_n(input logic [7:0] div);
      logic [2:0] n;
      n = div[DIV_N_HI:DIV_N_LO];
      return (n < N_MIN) ? N_MIN : n;
   endfunction : eff_n

   // True on the last prescaler tick of one (k+16) modulus period
   function automatic logic mod_hit(input logic [4:0] cnt, input logic [7:0] div);
      logic [3:0] k;
      k = div[DIV_K_HI:DIV_K_LO];
      if (k > K_MAX) begin
         k = K_MAX;
      end
      return cnt == (MOD_BASE + 5'(k) - 5'h01);
   endfunction : mod_hit

   // Register decode
   logic wr_data;
   logic wr_mode;
   logic wr_div;
   logic wr_stat;
   logic bit_mode;
   logic rd_data;
   logic async_on;
   logic len8;

   assign wr_data = reg_wr && (reg_addr == ADDR_DATA);
   assign wr_mode = reg_wr && (reg_addr == ADDR_MODE);
   assign wr_div = reg_wr && (reg_addr == ADDR_DIV);
   assign wr_stat = reg_wr && (reg_addr == ADDR_STAT);
   assign bit_mode = (reg_bit_set || reg_bit_clr) && (reg_addr == ADDR_MODE);
   assign rd_data = reg_rd && (reg_addr == ADDR_DATA);
   assign async_on = mode_q[MODE_ASYNC];
   assign len8 = mode_q[MODE_LEN8];

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_q <= MODE_RST;
      end else if (wr_mode) begin
         mode_q <= reg_wdata;
      end else if (bit_mode && reg_bit_set) begin
         mode_q[reg_bit_sel] <= 1'b1;
      end else if (bit_mode) begin
         mode_q[reg_bit_sel] <= 1'b0;
      end
   end

   // Bit operations on the divider are ignored on purpose
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         div_q <= DIV_RST;
      end else if (wr_div) begin
         div_q <= reg_wdata;
      end
   end

   // Prescaler: one tick every 2^n clocks, shared by both directions
   logic [6:0] pre_cnt_q;
   logic [6:0] pre_mask;
   logic pre_tick;

   assign pre_mask = 7'((8'h01 << eff_n(div_q)) - 8'h01);
   assign pre_tick = ((pre_cnt_q & pre_mask) == pre_mask);

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pre_cnt_q <= '0;
      end else begin
         pre_cnt_q <= pre_tick ? '0 : pre_cnt_q + 7'h01;
      end
   end

   // Transmitter
   tx_state_t tx_state_q;
   logic [7:0] tx_shift_q;
   logic [3:0] tx_bits_q;
   logic [4:0] tx_mod_q;
   logic tx_half_q;
   logic tx_go;
   logic tx_bit_end;
   logic tx_busy;

   assign tx_busy = (tx_state_q != TX_IDLE);
   // A write during a transfer is dropped rather than corrupting it
   assign tx_go = wr_data && async_on && mode_q[MODE_TX_EN] && !tx_busy;
   assign tx_bit_end = pre_tick && mod_hit(tx_mod_q, div_q) && tx_half_q;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_mod_q <= '0;
         tx_half_q <= 1'b0;
      end else if (!tx_busy) begin
         tx_mod_q <= '0;
         tx_half_q <= 1'b0;
      end else if (pre_tick && mod_hit(tx_mod_q, div_q)) begin
         tx_mod_q <= '0;
         tx_half_q <= !tx_half_q;
      end else if (pre_tick) begin
         tx_mod_q <= tx_mod_q + 5'h01;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_state_q <= TX_IDLE;
         tx_shift_q <= '0;
         tx_bits_q <= '0;
         txd_q <= 1'b1;
      end else begin
         unique case (tx_state_q)
            TX_IDLE: begin
               txd_q <= 1'b1;
               if (tx_go) begin
                  tx_shift_q <= reg_wdata;
                  tx_bits_q <= len8 ? BITS_8 : BITS_7;
                  tx_state_q <= TX_START;
                  txd_q <= 1'b0;
               end
            end
            TX_START: begin
               if (tx_bit_end) begin
                  txd_q <= tx_shift_q[0];
                  tx_shift_q <= {1'b0, tx_shift_q[7:1]};
                  tx_bits_q <= tx_bits_q - 4'h1;
                  tx_state_q <= TX_DATA;
               end
            end
            TX_DATA: begin
               if (tx_bit_end && tx_bits_q == 4'h0) begin
                  txd_q <= 1'b1;
                  tx_state_q <= TX_STOP;
               end else if (tx_bit_end) begin
                  txd_q <= tx_shift_q[0];
                  tx_shift_q <= {1'b0, tx_shift_q[7:1]};
                  tx_bits_q <= tx_bits_q - 4'h1;
               end
            end
            TX_STOP: begin
               if (tx_bit_end) begin
                  tx_state_q <= TX_IDLE;
               end
            end
         endcase
      end
   end

   // Receiver: line passes two flops before any logic sees it
   logic rxd_meta_q;
   logic rxd_s_q;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rxd_meta_q <= 1'b1;
         rxd_s_q <= 1'b1;
      end else begin
         rxd_meta_q <= rxd;
         rxd_s_q <= rxd_meta_q;
      end
   end

   rx_state_t rx_state_q;
   logic [7:0] rx_shift_q;
   logic [3:0] rx_bits_q;
   logic [4:0] rx_mod_q;
   logic rx_phase_q;
   logic rx_len8_q;
   logic rx_half_end;
   logic rx_sample;
   logic rx_on;
   logic rx_push;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [7:0] fifo_out_data;
   logic [7:0] rx_byte;
   logic overrun_set;
   logic frame_set;

   assign rx_on = async_on && mode_q[MODE_RX_EN];
   assign rx_half_end = pre_tick && mod_hit(rx_mod_q, div_q);
   assign rx_sample = rx_half_end && rx_phase_q;
   // Seven-bit characters land right aligned with a zero on top
   assign rx_byte = rx_len8_q ? rx_shift_q : {1'b0, rx_shift_q[7:1]};

   // Half-bit timer restarts at each start edge to centre the samples
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_mod_q <= '0;
         rx_phase_q <= 1'b0;
      end else if (rx_state_q == RX_IDLE) begin
         rx_mod_q <= '0;
         rx_phase_q <= 1'b0;
      end else if (rx_half_end) begin
         rx_mod_q <= '0;
         rx_phase_q <= (rx_state_q == RX_START) ? 1'b0 : !rx_phase_q;
      end else if (pre_tick) begin
         rx_mod_q <= rx_mod_q + 5'h01;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_state_q <= RX_IDLE;
         rx_shift_q <= '0;
         rx_bits_q <= '0;
         rx_len8_q <= 1'b1;
         rx_push <= 1'b0;
         overrun_set <= 1'b0;
         frame_set <= 1'b0;
      end else begin
         rx_push <= 1'b0;
         overrun_set <= 1'b0;
         frame_set <= 1'b0;
         unique case (rx_state_q)
            RX_IDLE: begin
               if (rx_on && !rxd_s_q) begin
                  rx_len8_q <= len8;
                  rx_bits_q <= len8 ? BITS_8 : BITS_7;
                  rx_state_q <= RX_START;
               end
            end
            RX_START: begin
               // A glitch shorter than half a bit is not a start
               if (rx_half_end) begin
                  rx_state_q <= rxd_s_q ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (rx_sample) begin
                  rx_shift_q <= {rxd_s_q, rx_shift_q[7:1]};
                  rx_bits_q <= rx_bits_q - 4'h1;
                  if (rx_bits_q == 4'h1) begin
                     rx_state_q <= RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               if (rx_sample) begin
                  rx_state_q <= RX_IDLE;
                  if (!rxd_s_q) begin
                     frame_set <= 1'b1;
                  end else if (fifo_in_ready) begin
                     rx_push <= 1'b1;
                  end else begin
                     overrun_set <= 1'b1;
                  end
               end
            end
         endcase
      end
   end

   // Push is registered one cycle after the stop sample; rx_shift_q holds still
   serial_rx_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_rx_fifo (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .in_valid(rx_push),
      .in_ready(fifo_in_ready),
      .in_data(rx_byte),
      .out_valid(fifo_out_valid),
      .out_ready(rd_data),
      .out_data(fifo_out_data)
   );

   // Sticky error flags, write one to clear, a new event wins
   logic overrun_q;
   logic frame_err_q;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         overrun_q <= 1'b0;
      end else if (overrun_set) begin
         overrun_q <= 1'b1;
      end else if (wr_stat && reg_wdata[STAT_OVERRUN]) begin
         overrun_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         frame_err_q <= 1'b0;
      end else if (frame_set) begin
         frame_err_q <= 1'b1;
      end else if (wr_stat && reg_wdata[STAT_FRAME_ERR]) begin
         frame_err_q <= 1'b0;
      end
   end

   logic [7:0] status;

   always_comb begin
      status = 8'h00;
      status[STAT_TX_BUSY] = tx_busy;
      status[STAT_RX_READY] = fifo_out_valid;
      status[STAT_OVERRUN] = overrun_q;
      status[STAT_FRAME_ERR] = frame_err_q;
   end

   // Read data is registered; an empty buffer reads as zero
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            ADDR_DATA: rdata_q <= fifo_out_valid ? fifo_out_data : 8'h00;
            ADDR_MODE: rdata_q <= mode_q;
            ADDR_DIV: rdata_q <= div_q;
            ADDR_STAT: rdata_q <= status;
         endcase
      end
   end

   assign reg_rdata = rdata_q;
   assign txd = txd_q;
endmodule : async_serial_port_with_baud_gen
`default_nettype wire

//--- sim/serial_port_properties.sv
// Bound checker for the serial port registers and transmit line
`timescale 1ns/100ps
`default_nettype none
module serial_port_properties
   import serial_port_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_bit_set,
   input wire logic reg_bit_clr,
   input wire logic [2:0] reg_bit_sel,
   input wire logic [7:0] reg_rdata,
   // Serial line
   input wire logic rxd,
   input wire logic txd
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   logic [7:0] mode_q, div_q, byte_q;
   logic len8_q, go, cen;
   int since_q, t_q, t_cur, n_cur, slack_q, idx, nb;
   assign n_cur = div_q[6:4] < N_MIN ? N_MIN : div_q[6:4];
   assign t_cur = (2 << n_cur) * ((div_q[3:0] > K_MAX ? K_MAX : div_q[3:0]) + MOD_BASE);
   // Start bit may be short by up to one prescaler period, so busy can drop that early
   assign go = reg_wr && reg_addr == ADDR_DATA && mode_q[MODE_TX_EN] && mode_q[MODE_ASYNC]
      && since_q + slack_q > (nb + 2) * t_q;
   assign idx = since_q / t_q;
   assign cen = since_q % t_q == t_q / 2;
   assign nb = len8_q ? 8 : 7;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_q <= MODE_RST;
         div_q <= DIV_RST;
      end else if (reg_addr == ADDR_DIV && reg_wr) begin
         div_q <= reg_wdata;
      end else if (reg_addr == ADDR_MODE && reg_wr) begin
         mode_q <= reg_wdata;
      end else if (reg_addr == ADDR_MODE && reg_bit_set) begin
         mode_q[reg_bit_sel] <= 1'b1;
      end else if (reg_addr == ADDR_MODE && reg_bit_clr) begin
         mode_q[reg_bit_sel] <= 1'b0;
      end
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         since_q <= 1 << 20;
         t_q <= 64;
         slack_q <= 2;
         byte_q <= 8'h00;
         len8_q <= 1'b1;
      end else if (go) begin
         since_q <= 0;
         t_q <= t_cur;
         slack_q <= 1 << n_cur;
         byte_q <= reg_wdata;
         len8_q <= mode_q[MODE_LEN8];
      end else if (since_q < 1 << 20) begin
         since_q <= since_q + 1;
      end
   end
   a_start_low: assert property (go |=> !txd) else $error("no start bit after write");
   a_start_hold: assert property (go |=> (!txd) [*8]) else $error("start bit too short");
   a_data_bit: assert property (cen && idx >= 1 && idx <= nb |-> txd == byte_q[idx - 1])
      else $error("wrong data bit on txd");
   a_stop_high: assert property (cen && idx == nb + 1 |-> txd) else $error("stop bit low");
   a_idle_high: assert property (since_q >= (nb + 2) * t_q |-> txd) else $error("line not idle high");
   a_mode_read: assert property (reg_rd && reg_addr == ADDR_MODE |=> reg_rdata == $past(mode_q))
      else $error("mode readback wrong");
   a_div_read: assert property (reg_rd && reg_addr == ADDR_DIV |=> reg_rdata == $past(div_q))
      else $error("divider readback wrong");
   a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
   a_rx_msb_zero: assert property (reg_rd && reg_addr == ADDR_DATA && !mode_q[MODE_LEN8] |=> !reg_rdata[7])
      else $error("seven-bit receive msb set");
   c_tx_start: cover property (go);
   c_rx_read: cover property (reg_rd && reg_addr == ADDR_DATA && reg_rdata != 8'h00);
   c_bit_op: cover property (reg_bit_set && reg_addr == ADDR_MODE);
   c_frame_err: cover property (reg_rd && reg_addr == ADDR_STAT ##1 reg_rdata[STAT_FRAME_ERR]);
endmodule : serial_port_properties
bind async_serial_port_with_baud_gen serial_port_properties u_props (.core_clk, .arst_n, .reg_addr, .reg_wr,
   .reg_rd, .reg_wdata, .reg_bit_set, .reg_bit_clr, .reg_bit_sel, .reg_rdata, .rxd, .txd);
`default_nettype wire

//--- sim/serial_remote_model.sv
// Behavioural far-end transceiver on the serial line
`timescale 1ns/100ps
`default_nettype none
module serial_remote_model (
   // Clock and bit timing
   input wire logic core_clk,
   input wire logic [15:0] bit_clks,
   input wire logic [3:0] nbits,
   // Serial line
   input wire logic txd,
   output logic rxd,
   // Bench control
   input wire logic send_go,
   input wire logic [7:0] send_data,
   output logic sending,
   output logic [7:0] got_data,
   output logic [7:0] got_count
);
   initial begin : sender
      rxd = 1'b1;
      sending = 1'b0;
      forever begin
         @(posedge core_clk);
         if (send_go) begin
            sending <= 1'b1;
            rxd <= 1'b0;
            repeat (bit_clks) @(posedge core_clk);
            for (int i = 0; i < nbits; i++) begin
               rxd <= send_data[i];
               repeat (bit_clks) @(posedge core_clk);
            end
            rxd <= 1'b1;
            repeat (bit_clks) @(posedge core_clk);
            sending <= 1'b0;
         end
      end
   end
   // Non-blocking results so the bench never races the update
   initial begin : receiver
      logic [7:0] b;
      got_data = 8'h00;
      got_count = 8'h00;
      forever begin
         @(negedge txd);
         b = 8'h00;
         repeat (bit_clks / 2) @(posedge core_clk);
         for (int i = 0; i < nbits; i++) begin
            repeat (bit_clks) @(posedge core_clk);
            b[i] = txd;
         end
         repeat (bit_clks) @(posedge core_clk);
         if (txd === 1'b1) begin
            got_data <= b;
            got_count <= got_count + 8'h01;
         end
      end
   end
endmodule : serial_remote_model
`default_nettype wire

//--- sim/testbench.sv
// Self-checking register-level testbench for the serial port
`timescale 1ns/100ps
`default_nettype none
module testbench
   import serial_port_pkg::*;
;
   logic core_clk, arst_n, reg_wr, reg_rd, reg_bit_set, reg_bit_clr, rxd, txd, send_go, sending;
   logic [ADDR_W-1:0] reg_addr;
   logic [2:0] reg_bit_sel;
   logic [7:0] reg_wdata, reg_rdata, send_data, got_data, got_count, rd_v, c;
   logic [15:0] bit_clks = 16'h0040;
   logic [3:0] nbits = 4'h8;
   logic [7:0] dv [3] = '{8'h2e, 8'h0f, 8'h10};
   int fails = 0, cmp_count = 0, cycles = 0;

   async_serial_port_with_baud_gen u_dut (.core_clk, .arst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
      .reg_bit_set, .reg_bit_clr, .reg_bit_sel, .reg_rdata, .rxd, .txd);
   serial_remote_model u_remote (.core_clk, .bit_clks, .nbits, .txd, .rxd, .send_go, .send_data, .sending,
      .got_data, .got_count);

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   function automatic logic [15:0] bt(input logic [7:0] d);
      return 16'((2 << (d[6:4] == 3'h0 ? 1 : d[6:4])) * ((d[3:0] == 4'hf ? 14 : d[3:0]) + 16));
   endfunction : bt

   // Kind 0 write, 1 bit set, 2 bit clear, 3 read
   task automatic req(input int k, input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_bit_sel <= d[2:0];
      reg_wr <= k == 0;
      reg_bit_set <= k == 1;
      reg_bit_clr <= k == 2;
      reg_rd <= k == 3;
      @(posedge core_clk);
      {reg_wr, reg_bit_set, reg_bit_clr, reg_rd} <= 4'h0;
      #1 rd_v = reg_rdata;
   endtask : req

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic rchk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
      req(3, a, 8'h00);
      chk(rd_v, exp);
   endtask : rchk

   task automatic tx_chk(input logic [7:0] d, input logic [7:0] e);
      c = got_count;
      req(0, ADDR_DATA, d);
      req(3, ADDR_STAT, 8'h00);
      chk(rd_v & 8'h01, 8'h01);
      rchk(ADDR_DATA, 8'h00);
      for (int i = 0; i < 4000 && got_count === c; i++) @(posedge core_clk);
      chk(got_data, e);
      req(3, ADDR_STAT, 8'h00);
      repeat (300) if (rd_v[STAT_TX_BUSY] !== 1'b0) req(3, ADDR_STAT, 8'h00);
      chk(rd_v & 8'h01, 8'h00);
   endtask : tx_chk

   task automatic send_char(input logic [7:0] d);
      @(posedge core_clk);
      send_data <= d;
      send_go <= 1'b1;
      @(posedge core_clk);
      send_go <= 1'b0;
      #1;
      for (int i = 0; i < 4000 && sending === 1'b1; i++) @(posedge core_clk);
   endtask : send_char

   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop

   // Whole run needs about 14000 cycles
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         fails++;
         report_and_stop();
      end
   end

   initial begin : main
      {reg_wr, reg_rd, reg_bit_set, reg_bit_clr, send_go, arst_n} = 6'h00;
      {reg_wdata, send_data, reg_bit_sel, reg_addr} = 21'h0_0000;
      repeat (8) @(posedge core_clk);
      arst_n <= 1'b1;
      rchk(ADDR_MODE, MODE_RST);
      rchk(ADDR_DIV, DIV_RST);
      rchk(ADDR_DATA, 8'h00);
      for (int b = 2; b < 8; b++) req(1, ADDR_MODE, 8'(b));
      for (int b = 2; b < 5; b++) req(2, ADDR_MODE, 8'(b));
      rchk(ADDR_MODE, 8'he0);
      req(1, ADDR_DIV, 8'h07);
      rchk(ADDR_DIV, DIV_RST);
      req(0, ADDR_MODE, 8'he4);
      foreach (dv[i]) begin
         req(0, ADDR_DIV, dv[i]);
         bit_clks = bt(dv[i]);
         tx_chk(~dv[i], ~dv[i]);
      end
      // Asynchronous select off: neither direction may move
      req(0, ADDR_MODE, 8'hc4);
      c = got_count;
      req(0, ADDR_DATA, 8'h3c);
      repeat (704) @(posedge core_clk);
      chk(got_count, c);
      send_char(8'h5a);
      rchk(ADDR_STAT, 8'h00);
      req(0, ADDR_MODE, 8'he0);
      nbits = 4'h7;
      tx_chk(8'hd5, 8'h55);
      send_char(8'hff);
      rchk(ADDR_DATA, 8'h7f);
      req(0, ADDR_MODE, 8'he4);
      nbits = 4'h8;
      req(0, ADDR_DATA, 8'h81);
      for (int i = 0; i < 9; i++) send_char(8'h30 + 8'(i));
      chk(got_data, 8'h81);
      rchk(ADDR_STAT, 8'h06);
      for (int i = 0; i < 8; i++) rchk(ADDR_DATA, 8'h30 + 8'(i));
      rchk(ADDR_STAT, 8'h04);
      req(0, ADDR_STAT, 8'h04);
      rchk(ADDR_STAT, 8'h00);
      rchk(ADDR_DATA, 8'h00);
      // Far end at half speed: the stop sample lands in a zero data bit
      bit_clks = 16'h0080;
      send_char(8'h00);
      req(3, ADDR_STAT, 8'h00);
      chk(rd_v & 8'h0a, 8'h0a);
      req(3, ADDR_DATA, 8'h00);
      chk(rd_v & 8'h7f, 8'h00);
      req(0, ADDR_STAT, 8'h08);
      rchk(ADDR_STAT, 8'h00);
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
